// ---- verilog/dee_pkg.sv ----
// Purpose: Shared constants and types for the data EEPROM access controller
// Assumes: Registers reached by the core's special function register port
// Notes:   Offsets are the core's register file addresses
package dee_pkg;
    localparam int          DEPTH        = 64;
    localparam int          AW           = 6;
    localparam logic [7:0]  OFS_DATA     = 8'h08;
    localparam logic [7:0]  OFS_ADDR     = 8'h09;
    localparam logic [7:0]  OFS_CTRL     = 8'h88;
    localparam logic [7:0]  OFS_UNLOCK   = 8'h89;
    localparam int          BIT_DONE     = 4;
    localparam int          BIT_ERR      = 3;
    localparam int          BIT_PERMIT   = 2;
    localparam int          BIT_WSTART   = 1;
    localparam int          BIT_RSTART   = 0;
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;
    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam int          WRITE_NS     = 4000;
    localparam int          CLK_NS       = 20;
    localparam int          WRITE_CYC    = (WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CW           = 16;

    typedef struct packed {
        logic       write_permit_bit;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dee_sfr_req_t;

    typedef enum logic [2:0] {
        UNL_IDLE  = 3'b001,
        UNL_FIRST = 3'b010,
        UNL_ARMED = 3'b100
    } dee_unlock_t;
endpackage

// ---- verilog/dee_ctrl.sv ----
// Purpose: Data EEPROM access controller behind four special function registers
// Assumes: One core clock; core accesses are single-cycle strobes on sfrReq
// Notes:   Write cycle length is a parameter; resets abort writes via abortReq
// How it works
// - Sixty-four byte locations, 0h to 3Fh, readable and writable by software.
// - A byte write erases the location first, then programs the new byte.
// - Write duration set by an internal timer; hardware signals completion.
// - Code protection blocks the external programmer but not the processor.
// - Address register is 8 bits; top two bits not decoded, software keeps them zero.
// - Control register has five bits; bits 7 to 5 read zero.
// - Hardware sets done flag bit 4 at write end; only software clears it.
// - Error flag bit 3 sets when master-clear or watchdog aborts a write.
// - Permit bit 2 allows writes when one, blocks them when zero; reset clear.
// - Write-start and read-start bits are set-only; hardware clears them.
// - Read-start loads the addressed byte into data register next cycle.
// - Data register holds a fetched byte until another read or software write.
// - Aborted write leaves address and data registers unchanged.
// - Unlock register has no storage and reads all zeros.
// - Write starts only after 55h then AAh to unlock, then write-start.
// - Setting write-start while permit is zero is ignored.
// - Clearing permit during a running write does not stop it.
`timescale 1ns/1ns
module dee_ctrl #(
    parameter int WRITE_CYCLES = dee_pkg::WRITE_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire dee_pkg::dee_sfr_req_t sfrReq,
    output logic [7:0]                 sfrRdata,
    input  wire logic                  abortReq,
    input  wire logic                  codeProtect,
    input  wire logic                  progReq,
    input  wire logic                  progWrite,
    input  wire logic [5:0]            progAddr,
    input  wire logic [7:0]            progWdata,
    output logic [7:0]                 progRdata,
    output logic                       writeBusy
);
    logic [7:0]            mem [dee_pkg::DEPTH];
    logic [7:0]            dataQ, dataD;
    logic [7:0]            addrQ, addrD;
    logic                  doneQ, doneD;
    logic                  errQ, errD;
    logic                  permitQ, permitD;
    logic                  wstartQ, wstartD;
    logic                  rstartQ, rstartD;
    logic [dee_pkg::CW-1:0] cntQ, cntD;
    dee_pkg::dee_unlock_t  unlQ, unlD;
    logic [7:0]            rdataQ, rdataD;
    logic [7:0]            progRdataQ, progRdataD;
    logic                  ctrlWr, unlockWr, dataWr, addrWr;
    logic                  startWrite, finishWrite, memWe;
    logic [7:0]            memWdata;
    logic [5:0]            memAddr;
    logic                  progAllowed;
    logic [7:0]            ctrlView;

    assign ctrlWr   = sfrReq.write_permit_bit && (sfrReq.addr == dee_pkg::OFS_CTRL);
    assign unlockWr = sfrReq.write_permit_bit && (sfrReq.addr == dee_pkg::OFS_UNLOCK);
    assign dataWr   = sfrReq.write_permit_bit && (sfrReq.addr == dee_pkg::OFS_DATA);
    assign addrWr   = sfrReq.write_permit_bit && (sfrReq.addr == dee_pkg::OFS_ADDR);

    // Programmer path only when unprotected and no write runs
    assign progAllowed = progReq && !codeProtect && !wstartQ;

    // Start needs armed sequence and permit
    assign startWrite  = ctrlWr && sfrReq.wdata[dee_pkg::BIT_WSTART] && !wstartQ
                         && permitQ && (unlQ == dee_pkg::UNL_ARMED) && !abortReq;
    // Timer runs out regardless of permit
    assign finishWrite = wstartQ && !abortReq
                         && (cntQ == dee_pkg::CW'(WRITE_CYCLES - 1));
    assign writeBusy   = wstartQ;

    // Whole-byte program replaces old content: erase then write
    assign memWe    = finishWrite || (progAllowed && progWrite);
    assign memAddr  = finishWrite ? addrQ[5:0] : progAddr;
    assign memWdata = finishWrite ? dataQ : progWdata;

    assign ctrlView = {3'b000, doneQ, errQ, permitQ, wstartQ, rstartQ};

    always_comb
    begin
        unlD = unlQ;
        if (unlockWr)
        begin
            if (sfrReq.wdata == dee_pkg::KEY_FIRST)
                unlD = dee_pkg::UNL_FIRST;
            else if (sfrReq.wdata == dee_pkg::KEY_SECOND && unlQ == dee_pkg::UNL_FIRST)
                unlD = dee_pkg::UNL_ARMED;
            else
                unlD = dee_pkg::UNL_IDLE;
        end
        else if (sfrReq.write_permit_bit || abortReq)
            unlD = dee_pkg::UNL_IDLE;  // Any other write breaks the sequence
    end

    always_comb
    begin
        dataD    = dataQ;
        addrD    = addrQ;
        doneD    = doneQ;
        errD     = errQ;
        permitD  = permitQ;
        wstartD  = wstartQ;
        rstartD  = 1'b0;
        cntD     = cntQ;
        if (dataWr)
            dataD = sfrReq.wdata;
        if (addrWr)
            addrD = sfrReq.wdata;
        if (ctrlWr)
        begin
            permitD = sfrReq.wdata[dee_pkg::BIT_PERMIT];
            errD    = sfrReq.wdata[dee_pkg::BIT_ERR];
            doneD   = sfrReq.wdata[dee_pkg::BIT_DONE];
            if (sfrReq.wdata[dee_pkg::BIT_RSTART])
            begin
                rstartD = 1'b1;  // Single-cycle read
                dataD   = mem[addrQ[5:0]];
            end
        end
        if (startWrite)
        begin
            wstartD = 1'b1;
            cntD    = '0;
        end
        else if (wstartQ)
            cntD = cntQ + dee_pkg::CW'(1);
        if (finishWrite)
        begin
            wstartD = 1'b0;
            doneD   = 1'b1;  // Set beats clear
        end
        if (abortReq && wstartQ)
        begin
            wstartD = 1'b0;
            errD    = 1'b1;  // Address and data kept
            cntD    = '0;
            dataD   = dataQ;
            addrD   = addrQ;
        end
        if (abortReq)
            permitD = 1'b0;
    end

    always_comb
    begin
        unique case (sfrReq.addr)
            dee_pkg::OFS_DATA:   rdataD = dataQ;
            dee_pkg::OFS_ADDR:   rdataD = addrQ;
            dee_pkg::OFS_CTRL:   rdataD = ctrlView;
            dee_pkg::OFS_UNLOCK: rdataD = 8'h00;
            default:             rdataD = 8'h00;
        endcase
        progRdataD = progRdataQ;
        if (progAllowed && !progWrite)
            progRdataD = mem[progAddr];
        else if (progReq && codeProtect)
            progRdataD = 8'h00;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataQ      <= dee_pkg::RST_REG;
            addrQ      <= dee_pkg::RST_REG;
            doneQ      <= 1'b0;
            errQ       <= 1'b0;
            permitQ    <= 1'b0;
            wstartQ    <= 1'b0;
            rstartQ    <= 1'b0;
            cntQ       <= '0;
            unlQ       <= dee_pkg::UNL_IDLE;
            rdataQ     <= dee_pkg::RST_REG;
            progRdataQ <= dee_pkg::RST_REG;
        end
        else
        begin
            dataQ      <= dataD;
            addrQ      <= addrD;
            doneQ      <= doneD;
            errQ       <= errD;
            permitQ    <= permitD;
            wstartQ    <= wstartD;
            rstartQ    <= rstartD;
            cntQ       <= cntD;
            unlQ       <= unlD;
            rdataQ     <= rdataD;
            progRdataQ <= progRdataD;
        end
    end

    // Cell array keeps contents through reset
    always_ff @(posedge core_clk)
    begin
        if (memWe)
            mem[memAddr] <= memWdata;
    end

    assign sfrRdata  = rdataQ;
    assign progRdata = progRdataQ;
endmodule

// ---- tb/dee_prog_model.sv ----
// Purpose: External programmer model on the device's programming port
// Assumes: Read-only use; one-cycle request strobes
// Notes:   Launches a request on the edge after go is seen
`timescale 1ns/1ns
module dee_prog_model (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [5:0] a,
    output logic            req,
    output logic [5:0]      addr
);
    always_ff @(posedge core_clk)
    begin
        req  <= go;
        addr <= a;
    end
endmodule

// ---- tb/dee_ctrl_props.sv ----
// Purpose: Port-level checks of the EEPROM access controller
// Assumes: Bound to dee_ctrl
// Notes:   Busy window bound is loose to allow WRITE_CYCLES up to 12
`timescale 1ns/1ns
module dee_ctrl_props #(
    parameter int WRITE_CYCLES = 8
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire dee_pkg::dee_sfr_req_t sfrReq,
    input wire logic [7:0]            sfrRdata,
    input wire logic                  abortReq,
    input wire logic                  codeProtect,
    input wire logic                  progReq,
    input wire logic [7:0]            progRdata,
    input wire logic                  writeBusy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_BUSY_ENDS:
        assert property ($rose(writeBusy) |-> ##[1:12] !writeBusy)
        else $error("write never completed");
    AST_ABORT_STOPS:
        assert property (abortReq && writeBusy |=> !writeBusy)
        else $error("abort did not stop write");
    AST_CTRL_TOP_ZERO:
        assert property ($past(sfrReq.addr) == 8'h88 |-> sfrRdata[7:5] == 3'h0)
        else $error("control top bits nonzero");
    AST_UNLOCK_ZERO:
        assert property ($past(sfrReq.addr) == 8'h89 |-> sfrRdata == 8'h00)
        else $error("unlock read nonzero");
    AST_START_CAUSE:
        assert property ($rose(writeBusy)
            |-> $past(sfrReq.write_permit_bit && sfrReq.addr == 8'h88 && sfrReq.wdata[1]))
        else $error("write began without start write");
    AST_PROG_BLOCK:
        assert property (codeProtect && progReq |=> progRdata == 8'h00)
        else $error("programmer read while protected");
    AST_BUSY_BIT:
        assert property ($past(sfrReq.addr) == 8'h88 |-> sfrRdata[1] == $past(writeBusy))
        else $error("start bit differs from busy");
    AST_IDLE_STAYS:
        assert property (!writeBusy && !sfrReq.write_permit_bit |=> !writeBusy)
        else $error("busy rose without a write");
endmodule
bind dee_ctrl dee_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.core_clk(core_clk),
    .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .abortReq(abortReq),
    .codeProtect(codeProtect), .progReq(progReq), .progRdata(progRdata), .writeBusy(writeBusy));

// ---- tb/data_eeprom_access_ctrl_test.sv ----
// Purpose: Self-checking bench for the EEPROM access controller
// Assumes: Write cycle shortened to 8 clocks
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ns
module data_eeprom_access_ctrl_test;
    logic core_clk = 0, rst_n = 0, abortReq = 0, codeProtect = 1, go = 0, progReq;
    logic [5:0] progAddr;
    logic [7:0] sfrRdata, progRdata;
    logic writeBusy;
    dee_pkg::dee_sfr_req_t sfrReq = '0;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    dee_ctrl #(.WRITE_CYCLES(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata), .abortReq(abortReq), .codeProtect(codeProtect), .progReq(progReq),
        .progWrite(1'b0), .progAddr(progAddr), .progWdata(8'h00), .progRdata(progRdata),
        .writeBusy(writeBusy));
    dee_prog_model prog (.core_clk(core_clk), .go(go), .a(6'h3F), .req(progReq), .addr(progAddr));
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            n_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe drops after its edge; one idle edge before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrReq = '{1'b1, 1'b0, a, d};
        @(posedge core_clk) #1;
        sfrReq.write_permit_bit = 1'b0;
        @(posedge core_clk) #1;
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        sfrReq.addr = a;
        @(posedge core_clk) #1 cmp(sfrRdata, exp);
    endtask
    task automatic seq(input logic [7:0] c);
        wr(8'h89, 8'h55);
        wr(8'h89, 8'hAA);
        wr(8'h88, c);
    endtask
    task automatic waitd();
        for (int i = 0; i < 40 && writeBusy === 1'b1; i++) @(posedge core_clk) #1;
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk);
        #1 rst_n = 1;
        chk(8'h88, 8'h00);
        chk(8'h89, 8'h00);
        wr(8'h09, 8'h3F);
        wr(8'h08, 8'hA5);
        wr(8'h88, 8'h04);
        seq(8'h06);
        chk(8'h88, 8'h06);
        waitd();
        chk(8'h88, 8'h14);
        wr(8'h08, 8'h00);
        wr(8'h88, 8'h05);
        chk(8'h08, 8'hA5);
        chk(8'h88, 8'h04);
        wr(8'h89, 8'hAA);
        wr(8'h89, 8'h55);
        wr(8'h88, 8'h06);
        chk(8'h88, 8'h04);
        wr(8'h88, 8'h00);
        seq(8'h02);
        chk(8'h88, 8'h00);
        wr(8'h09, 8'h05);
        wr(8'h08, 8'h3C);
        wr(8'h88, 8'h04);
        seq(8'h06);
        wr(8'h88, 8'h00);
        chk(8'h88, 8'h02);
        waitd();
        chk(8'h88, 8'h10);
        wr(8'h08, 8'h00);
        wr(8'h88, 8'h01);
        chk(8'h08, 8'h3C);
        wr(8'h88, 8'h04);
        seq(8'h06);
        abortReq = 1;
        @(posedge core_clk) #1;
        abortReq = 0;
        chk(8'h88, 8'h08);
        chk(8'h09, 8'h05);
        chk(8'h08, 8'h3C);
        go = 1;
        @(posedge core_clk) #1;
        go = 0;
        repeat (2) @(posedge core_clk) #1;
        cmp(progRdata, 8'h00);
        codeProtect = 0;
        go = 1;
        @(posedge core_clk) #1;
        go = 0;
        repeat (2) @(posedge core_clk) #1;
        cmp(progRdata, 8'hA5);
        summarize();
    end
endmodule
